// ==== design/ldp_pkg.sv ====
// shared constants and types for the diagnostic and protection controller
package ldp_pkg;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_HZ = 40000000;
	localparam int T_ON_SHORT_MS = 90;
	localparam int T_ON_LONG_MS = 180;
	localparam int T_OFF_MS = 900;
	localparam int SINK_TIMEOUT_MS = 10;
	localparam int CYC_PER_MS = CLK_HZ / 1000;
	localparam int T_ON_SHORT_CYC = T_ON_SHORT_MS * CYC_PER_MS;
	localparam int T_ON_LONG_CYC = T_ON_LONG_MS * CYC_PER_MS;
	localparam int T_OFF_CYC = T_OFF_MS * CYC_PER_MS;
	localparam int SINK_TIMEOUT_CYC = SINK_TIMEOUT_MS * CYC_PER_MS;
	localparam int TMR_W = 26;
	// ----------------------------------------
	// widths and reset values
	// ----------------------------------------
	localparam int LVL_W = 4;
	localparam logic [3:0] LVL_RESET = 4'h0;
	localparam logic [3:0] LVL_MAX = 4'hf;

	// pulsed-limit states
	typedef enum logic [2:0] {
		LDP_PL_IDLE = 3'b001,
		LDP_PL_ON = 3'b010,
		LDP_PL_OFF = 3'b100
	} ldp_pl_state_t;
endpackage : ldp_pkg

// ==== design/ldp_sec_if.sv ====
// per-section signals between the controller and its protection timer
`timescale 1ns/10ps
`default_nettype none
interface ldp_sec_if;
	logic overload;
	logic pulsed_disable;
	logic long_on;
	logic read_ack;
	logic out_off;
	logic flag;
	logic event_p;
	modport ctrl (output overload, output pulsed_disable, output long_on, output read_ack,
		input out_off, input flag, input event_p);
	modport prot (input overload, input pulsed_disable, input long_on, input read_ack,
		output out_off, output flag, output event_p);
endinterface : ldp_sec_if
`default_nettype wire

// ==== design/ldp_sec_prot.sv ====
// per-section overload protection: pulsed timer or static clamp with latched flag
`timescale 1ns/10ps
`default_nettype none
module ldp_sec_prot (
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire logic hold_i,
	ldp_sec_if.prot s
);
	import ldp_pkg::*;
	typedef struct packed {
		ldp_pl_state_t st;
		logic [TMR_W-1:0] tmr;
		logic seen;
		logic flag;
		logic off;
		logic ev;
	} ldp_prot_t;
	ldp_prot_t r, next_r;
	logic [TMR_W-1:0] ton;
	assign s.out_off = r.off;
	assign s.flag = r.flag;
	assign s.event_p = r.ev;
	always_comb begin
		next_r = r;
		next_r.ev = 1'b0;
		ton = s.long_on ? TMR_W'(T_ON_LONG_CYC) : TMR_W'(T_ON_SHORT_CYC);
		if (hold_i) begin
			next_r = '0;
			next_r.st = LDP_PL_IDLE;
		end else begin
			unique case (r.st)
			LDP_PL_IDLE: begin
				if (s.overload && s.pulsed_disable) begin
					next_r.flag = 1'b1;
					next_r.ev = ~r.flag;
				end else if (s.overload) begin
					next_r.st = LDP_PL_ON;
					next_r.tmr = '0;
					next_r.seen = 1'b1;
				end
			end
			LDP_PL_ON: begin
				next_r.tmr = r.tmr + 1'b1;
				if (s.overload)
					next_r.seen = 1'b1;
				if (r.tmr >= ton - 1'b1) begin
					if (r.seen || s.overload) begin
						next_r.st = LDP_PL_OFF;
						next_r.tmr = '0;
						next_r.off = 1'b1;
						next_r.flag = 1'b1;
						next_r.ev = 1'b1;
					end else begin
						next_r.st = LDP_PL_IDLE;
					end
				end
			end
			LDP_PL_OFF: begin
				next_r.tmr = r.tmr + 1'b1;
				if (r.tmr >= TMR_W'(T_OFF_CYC - 1)) begin
					next_r.st = LDP_PL_ON;
					next_r.tmr = '0;
					next_r.off = 1'b0;
					next_r.seen = 1'b0;
				end
			end
			default: next_r.st = LDP_PL_IDLE;
			endcase
			// flag drops only with cause gone and a read seen; set wins
			if (s.read_ack && !s.overload && r.st == LDP_PL_IDLE && !next_r.ev)
				next_r.flag = 1'b0;
		end
	end
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			r <= '{st: LDP_PL_IDLE, tmr: '0, seen: 1'b0, flag: 1'b0, off: 1'b0, ev: 1'b0};
		end else begin
			r <= next_r;
		end
	end
endmodule : ldp_sec_prot
`default_nettype wire

// ==== design/ldp_ctrl.sv ====
// diagnostic and protection controller for two supply sections
// Operation
// - enabled output below window holds output_voltage_low_flag high
// - tone amplitude or frequency out of limits sets tone_fault_flag
// - tone presence on detector input sets tone_detected_flag
// - with min-load check on, low current sets min_load_flag
// - min-load check forces output level to maximum
// - pull-down overcurrent beyond sink timeout sets pulldown_overcurrent_flag
// - under lockout, ignore writes and hold control bits at zero
// - above release threshold, host writes are accepted
// - low supply sets supply_low_flag and pulls fault pin low
// - switch limit select one picks lower current, zero higher
// - pulsed-limit disable zero means dynamic, one means static clamp
// - dynamic overload: on-time then fixed off-time shutdown
// - off-time start sets overload_flag and pulls fault pin low
// - cycle repeats while overloaded; clean on-time resumes normal
// - static clamp sets overload_flag; clears after cause gone and read
// - overload restart one clears section level and keeps it off
// - overload restart zero re-enables output automatically
// - over-temperature shuts boost and regulators, sets overtemp_flag, fault low
// - thermal restart one clears both level selects
// - thermal restart zero re-enables outputs when temperature clears
// - latched flags clear only after cause gone and status read; lockout also clears overload_flag without a read
// - fault pin low while any latched flag stays set
`timescale 1ns/10ps
`default_nettype none
module ldp_ctrl (
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire logic undervoltage_lockout_i,
	input wire logic supply_diag_threshold_i,
	input wire logic overtemp_i,
	input wire logic status_read_i,
	input wire logic ctrl_write_i,
	input wire logic [ldp_pkg::LVL_W-1:0] wr_output_level_select_a_i,
	input wire logic [ldp_pkg::LVL_W-1:0] wr_output_level_select_b_i,
	input wire logic [1:0] wr_switch_current_limit_sel_i,
	input wire logic [1:0] wr_pulsed_limit_disable_i,
	input wire logic [1:0] wr_on_time_select_i,
	input wire logic wr_min_load_check_enable_i,
	input wire logic wr_overload_restart_mode_i,
	input wire logic wr_thermal_restart_mode_i,
	input wire logic wr_boost_compensation_sel_i,
	input wire logic [1:0] vout_below_window_i,
	input wire logic [1:0] tone_out_of_limits_i,
	input wire logic [1:0] tone_detect_input_i,
	input wire logic [1:0] below_min_load_i,
	input wire logic [1:0] pulldown_overcurrent_i,
	input wire logic [1:0] overload_i,
	output logic [ldp_pkg::LVL_W-1:0] level_a_o,
	output logic [ldp_pkg::LVL_W-1:0] level_b_o,
	output logic [1:0] output_enable_o,
	output logic boost_enable_o,
	output logic [1:0] switch_current_limit_sel_o,
	output logic boost_compensation_sel_o,
	output logic i2c_enable_o,
	output logic [1:0] output_voltage_low_flag_o,
	output logic [1:0] tone_fault_flag_o,
	output logic [1:0] tone_detected_flag_o,
	output logic [1:0] min_load_flag_o,
	output logic [1:0] pulldown_overcurrent_flag_o,
	output logic [1:0] overload_flag_o,
	output logic overtemp_flag_o,
	output logic supply_low_flag_o,
	output logic fault_pin_n_o,
	output logic fault_pin_n_oe_o
);
	import ldp_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [2:0][2:0] sy; // async pins: 3-stage sync per bit group
		logic [2:0] syn; // filtered pin levels: lockout, low supply, overheat
		logic [1:0][LVL_W-1:0] lvl;
		logic [1:0] switch_current_limit_sel;
		logic [1:0] pulsed_limit_disable;
		logic [1:0] ton_long;
		logic min_load_en;
		logic overload_restart_mode;
		logic thermal_restart_mode;
		logic comp;
		logic [1:0][TMR_W-1:0] pd_tmr;
		logic [1:0] vlow;
		logic [1:0] tfault;
		logic [1:0] tone_detected_flag;
		logic [1:0] minld;
		logic [1:0] pulldown_overcurrent_flag;
		logic [1:0] overload_flag;
		logic overtemp_flag;
		logic supply_low_flag;
		logic [1:0][LVL_W-1:0] lvl_o;
		logic [1:0] oen;
		logic boost;
		logic i2c_en;
		logic flt_n;
	} ldp_st_t;
	ldp_st_t r, next_r;

	// synchroniser copies: index 0 first stage, 1 and 2 agreement stages
	logic uv_q, lpd_q, ot_q;
	logic ol_rise_any;
	logic [1:0] sec_off;
	logic [1:0] sec_flag;
	logic [1:0] sec_ev;
	logic [1:0] rd_ack;

	function automatic logic agree(input logic [2:0] s, input logic held);
		return (s[1] == s[2]) ? s[2] : held;
	endfunction : agree

	ldp_sec_if sif[2] ();

	for (genvar g = 0; g < 2; g++) begin : g_sec
		assign sif[g].overload = overload_i[g];
		assign sif[g].pulsed_disable = r.pulsed_limit_disable[g];
		assign sif[g].long_on = r.ton_long[g];
		assign sif[g].read_ack = status_read_i;
		assign sec_off[g] = sif[g].out_off;
		assign sec_flag[g] = sif[g].flag;
		assign sec_ev[g] = sif[g].event_p;
		ldp_sec_prot u_prot (
			.clock_i(clock_i),
			.nrst_i(nrst_i),
			.hold_i(uv_q),
			.s(sif[g])
		);
	end

	assign uv_q = r.syn[0];
	assign lpd_q = r.syn[1];
	assign ot_q = r.syn[2];
	assign ol_rise_any = |sec_ev;
	assign rd_ack = {2{status_read_i}};

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		next_r = r;
		// pins from other domains: three flops, change counted when 2 and 3 agree
		next_r.sy[0] = {r.sy[0][1], r.sy[0][0], undervoltage_lockout_i};
		next_r.sy[1] = {r.sy[1][1], r.sy[1][0], supply_diag_threshold_i};
		next_r.sy[2] = {r.sy[2][1], r.sy[2][0], overtemp_i};
		for (int i = 0; i < 3; i++) begin
			next_r.syn[i] = agree(r.sy[i], r.syn[i]);
		end

		// control register writes
		if (uv_q) begin
			next_r.lvl = '0;
			next_r.switch_current_limit_sel = '0;
			next_r.pulsed_limit_disable = '0;
			next_r.ton_long = '0;
			next_r.min_load_en = 1'b0;
			next_r.overload_restart_mode = 1'b0;
			next_r.thermal_restart_mode = 1'b0;
			next_r.comp = 1'b0;
		end else if (ctrl_write_i) begin
			next_r.lvl[0] = wr_output_level_select_a_i;
			next_r.lvl[1] = wr_output_level_select_b_i;
			next_r.switch_current_limit_sel = wr_switch_current_limit_sel_i;
			next_r.pulsed_limit_disable = wr_pulsed_limit_disable_i;
			next_r.ton_long = wr_on_time_select_i;
			next_r.min_load_en = wr_min_load_check_enable_i;
			next_r.overload_restart_mode = wr_overload_restart_mode_i;
			next_r.thermal_restart_mode = wr_thermal_restart_mode_i;
			next_r.comp = wr_boost_compensation_sel_i;
		end
		// restart modes clear levels; set of clear beats a same-cycle write
		for (int i = 0; i < 2; i++) begin
			if (!uv_q && r.overload_restart_mode && sec_ev[i])
				next_r.lvl[i] = LVL_RESET;
		end
		if (!uv_q && r.thermal_restart_mode && ot_q)
			next_r.lvl = '0;

		// per-section diagnostics
		for (int i = 0; i < 2; i++) begin
			next_r.vlow[i] = r.oen[i] & vout_below_window_i[i];
			next_r.tfault[i] = tone_out_of_limits_i[i];
			next_r.tone_detected_flag[i] = tone_detect_input_i[i];
			next_r.minld[i] = r.min_load_en & below_min_load_i[i];
			if (pulldown_overcurrent_i[i]) begin
				if (r.pd_tmr[i] < TMR_W'(SINK_TIMEOUT_CYC))
					next_r.pd_tmr[i] = r.pd_tmr[i] + 1'b1;
			end else begin
				next_r.pd_tmr[i] = '0;
			end
			next_r.pulldown_overcurrent_flag[i] = (r.pd_tmr[i] >= TMR_W'(SINK_TIMEOUT_CYC));
			next_r.overload_flag[i] = sec_flag[i];
		end

		// latched supply and temperature flags: set wins over read
		if (ot_q)
			next_r.overtemp_flag = 1'b1;
		else if (rd_ack[0])
			next_r.overtemp_flag = 1'b0;
		if (lpd_q)
			next_r.supply_low_flag = 1'b1;
		else if (rd_ack[1])
			next_r.supply_low_flag = 1'b0;

		// power stage drive
		next_r.boost = ~uv_q & ~ot_q;
		next_r.i2c_en = ~uv_q;
		for (int i = 0; i < 2; i++) begin
			next_r.lvl_o[i] = r.min_load_en ? LVL_MAX : r.lvl[i];
			// nonzero level enables; protection timer or overheat forces off
			next_r.oen[i] = (|r.lvl[i]) & ~sec_off[i] & ~overload_block(i) & ~ot_q;
		end
		// fault pin mirrors latched flags; ol_rise_any rises in the same cycle as sec_flag, so it pulls no earlier
		next_r.flt_n = ~(next_r.overtemp_flag | next_r.supply_low_flag | (|sec_flag) | ol_rise_any);
	end

	// static-mode output stays driven in clamp; automatic re-enable is implicit
	function automatic logic overload_block(input int idx);
		return 1'b0;
	endfunction : overload_block

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			r <= '0;
			// lockout starts asserted; supply and heat start quiet so no flag after reset
			r.sy <= '{3'b000, 3'b000, 3'b111};
			r.syn <= 3'b001;
			r.flt_n <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign level_a_o = r.lvl_o[0];
	assign level_b_o = r.lvl_o[1];
	assign output_enable_o = r.oen;
	assign boost_enable_o = r.boost;
	assign switch_current_limit_sel_o = r.switch_current_limit_sel;
	assign boost_compensation_sel_o = r.comp;
	assign i2c_enable_o = r.i2c_en;
	assign output_voltage_low_flag_o = r.vlow;
	assign tone_fault_flag_o = r.tfault;
	assign tone_detected_flag_o = r.tone_detected_flag;
	assign min_load_flag_o = r.minld;
	assign pulldown_overcurrent_flag_o = r.pulldown_overcurrent_flag;
	assign overload_flag_o = r.overload_flag;
	assign overtemp_flag_o = r.overtemp_flag;
	assign supply_low_flag_o = r.supply_low_flag;
	// open drain: drive low only, enable high while pulling
	assign fault_pin_n_o = 1'b0;
	assign fault_pin_n_oe_o = ~r.flt_n;
endmodule : ldp_ctrl
`default_nettype wire

// ==== sim/ldp_ctrl_checker.sv ====
// port assertions for the diagnostic and protection controller
`timescale 1ns/10ps
`default_nettype none
module ldp_ctrl_checker (
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire logic undervoltage_lockout_i,
	input wire logic supply_diag_threshold_i,
	input wire logic overtemp_i,
	input wire logic status_read_i,
	input wire logic ctrl_write_i,
	input wire logic [1:0] wr_switch_current_limit_sel_i,
	input wire logic wr_min_load_check_enable_i,
	input wire logic [1:0] vout_below_window_i,
	input wire logic [1:0] tone_detect_input_i,
	input wire logic [ldp_pkg::LVL_W-1:0] level_a_o,
	input wire logic [ldp_pkg::LVL_W-1:0] level_b_o,
	input wire logic [1:0] output_enable_o,
	input wire logic boost_enable_o,
	input wire logic [1:0] switch_current_limit_sel_o,
	input wire logic i2c_enable_o,
	input wire logic [1:0] output_voltage_low_flag_o,
	input wire logic [1:0] tone_detected_flag_o,
	input wire logic [1:0] overload_flag_o,
	input wire logic overtemp_flag_o,
	input wire logic supply_low_flag_o,
	input wire logic fault_pin_n_oe_o
);
	import ldp_pkg::*;
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!nrst_i);
	// ----------------------------------------
	// checks
	// ----------------------------------------
	// repetition counts cover the three-flop synchroniser plus output stages
	lock_holds_a: assert property (undervoltage_lockout_i [*8] |-> !i2c_enable_o &&
		output_enable_o == 2'h0 && level_a_o == 4'h0) else $error("lockout left control set");
	iface_up_a: assert property (!undervoltage_lockout_i [*8] |-> i2c_enable_o)
		else $error("interface not enabled");
	write_lands_a: assert property (ctrl_write_i && i2c_enable_o |-> ##2
		switch_current_limit_sel_o == $past(wr_switch_current_limit_sel_i, 2))
		else $error("switch limit select not taken");
	min_load_max_a: assert property (ctrl_write_i && i2c_enable_o && wr_min_load_check_enable_i &&
		!overtemp_flag_o |-> ##2 level_a_o == 4'hf && level_b_o == 4'hf)
		else $error("level not forced high");
	low_flag_a: assert property (vout_below_window_i[0] && output_enable_o[0] |=>
		output_voltage_low_flag_o[0]) else $error("voltage low flag missing");
	tone_seen_a: assert property (tone_detect_input_i[1] |=> tone_detected_flag_o[1])
		else $error("tone detect flag missing");
	supply_low_a: assert property (supply_diag_threshold_i [*6] |-> supply_low_flag_o &&
		fault_pin_n_oe_o) else $error("supply low not flagged");
	hot_off_a: assert property (overtemp_i [*7] |-> overtemp_flag_o && !boost_enable_o &&
		output_enable_o == 2'h0 && fault_pin_n_oe_o) else $error("overheat not handled");
	fault_low_a: assert property (overload_flag_o != 2'h0 || overtemp_flag_o ||
		supply_low_flag_o |-> fault_pin_n_oe_o) else $error("fault pin released");
	hold_flag_a: assert property (overload_flag_o[0] && !status_read_i &&
		!$past(status_read_i) |=> overload_flag_o[0]) else $error("overload flag dropped");
endmodule : ldp_ctrl_checker
bind ldp_ctrl ldp_ctrl_checker i_chk (.*);
`default_nettype wire

// ==== sim/ldp_host_model.sv ====
// host side model: control word writes and status reads
`timescale 1ns/10ps
`default_nettype none
module ldp_host_model (
	input wire logic clock_i,
	output logic status_read_o,
	output logic ctrl_write_o,
	output logic [ldp_pkg::LVL_W-1:0] lvl_a_o,
	output logic [ldp_pkg::LVL_W-1:0] lvl_b_o,
	output logic [1:0] cur_sel_o,
	output logic [1:0] clamp_o,
	output logic [1:0] long_on_o,
	output logic [3:0] mode_o
);
	import ldp_pkg::*;
	initial begin
		status_read_o = 1'b0;
		ctrl_write_o = 1'b0;
		{lvl_a_o, lvl_b_o, cur_sel_o, clamp_o, long_on_o, mode_o} = 18'h0_0000;
	end
	// mode: min-load check, overload restart, thermal restart, compensation (always written as zero)
	task automatic write_ctrl(input logic [3:0] a, input logic [3:0] b, input logic [1:0] c,
		input logic [1:0] p, input logic [1:0] t, input logic [3:0] m);
		@(posedge clock_i);
		#1;
		{lvl_a_o, lvl_b_o, cur_sel_o, clamp_o, long_on_o, mode_o} = {a, b, c, p, t, m[3:1], 1'b0};
		ctrl_write_o = 1'b1;
		@(posedge clock_i);
		#1;
		ctrl_write_o = 1'b0;
	endtask : write_ctrl
	task automatic read_status();
		@(posedge clock_i);
		#1;
		status_read_o = 1'b1;
		@(posedge clock_i);
		#1;
		status_read_o = 1'b0;
	endtask : read_status
endmodule : ldp_host_model
`default_nettype wire

// ==== sim/ldp_ctrl_bench.sv ====
// self-checking bench for the diagnostic and protection controller
`timescale 1ns/10ps
`default_nettype none
module ldp_ctrl_bench;
	import ldp_pkg::*;
	logic clock_i = 1'b0;
	logic nrst_i = 1'b0;
	logic undervoltage_lockout_i = 1'b1, supply_diag_threshold_i = 1'b0, overtemp_i = 1'b0;
	logic status_read_i, ctrl_write_i, wr_min_load_check_enable_i, wr_overload_restart_mode_i;
	logic wr_thermal_restart_mode_i, wr_boost_compensation_sel_i;
	logic [3:0] wr_output_level_select_a_i, wr_output_level_select_b_i, level_a_o, level_b_o;
	logic [1:0] wr_switch_current_limit_sel_i, wr_pulsed_limit_disable_i, wr_on_time_select_i;
	logic [1:0] vout_below_window_i = 2'h0, tone_out_of_limits_i = 2'h0, tone_detect_input_i = 2'h0;
	logic [1:0] below_min_load_i = 2'h0, pulldown_overcurrent_i = 2'h0, overload_i = 2'h0;
	logic [1:0] output_enable_o, switch_current_limit_sel_o, output_voltage_low_flag_o;
	logic [1:0] tone_fault_flag_o, tone_detected_flag_o, min_load_flag_o;
	logic [1:0] pulldown_overcurrent_flag_o, overload_flag_o;
	logic boost_enable_o, boost_compensation_sel_o, i2c_enable_o, overtemp_flag_o;
	logic supply_low_flag_o, fault_pin_n_o, fault_pin_n_oe_o;
	int err_count = 0;
	int comparisons = 0;
	always #12.5 clock_i = ~clock_i;
	ldp_ctrl i_dut (.*);
	ldp_host_model i_host (.clock_i(clock_i), .status_read_o(status_read_i),
		.ctrl_write_o(ctrl_write_i), .lvl_a_o(wr_output_level_select_a_i),
		.lvl_b_o(wr_output_level_select_b_i), .cur_sel_o(wr_switch_current_limit_sel_i),
		.clamp_o(wr_pulsed_limit_disable_i), .long_on_o(wr_on_time_select_i),
		.mode_o({wr_min_load_check_enable_i, wr_overload_restart_mode_i,
		wr_thermal_restart_mode_i, wr_boost_compensation_sel_i}));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic step(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask : step
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : summarize
	// guards against a hang; the sequence needs far fewer cycles
	initial begin
		#2500000;
		err_count++;
		summarize();
	end
	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		step(16);
		nrst_i = 1'b1;
		i_host.write_ctrl(4'h5, 4'h5, 2'h3, 2'h3, 2'h0, 4'h0);
		step(4);
		check({i2c_enable_o, level_a_o}, 5'h00);
		undervoltage_lockout_i = 1'b0;
		step(8);
		check(i2c_enable_o, 1'b1);
		i_host.write_ctrl(4'h5, 4'ha, 2'h1, 2'h3, 2'h0, 4'h1);
		step(3);
		check({level_a_o, level_b_o, output_enable_o}, 10'h16b);
		check({switch_current_limit_sel_o, boost_compensation_sel_o}, 3'h2);
		vout_below_window_i = 2'h1;
		tone_out_of_limits_i = 2'h2;
		tone_detect_input_i = 2'h3;
		step(3);
		check(output_voltage_low_flag_o, 2'h1);
		check(tone_fault_flag_o, 2'h2);
		check(tone_detected_flag_o, 2'h3);
		vout_below_window_i = 2'h0;
		tone_out_of_limits_i = 2'h0;
		tone_detect_input_i = 2'h0;
		i_host.write_ctrl(4'h5, 4'ha, 2'h1, 2'h3, 2'h0, 4'h8);
		below_min_load_i = 2'h2;
		step(3);
		check({level_a_o, level_b_o}, 8'hff);
		check(min_load_flag_o, 2'h2);
		below_min_load_i = 2'h0;
		pulldown_overcurrent_i = 2'h1;
		step(1000);
		check(pulldown_overcurrent_flag_o, 2'h0);
		pulldown_overcurrent_i = 2'h0;
		i_host.write_ctrl(4'h5, 4'ha, 2'h1, 2'h3, 2'h0, 4'h0);
		overload_i = 2'h1;
		step(3);
		check({overload_flag_o, fault_pin_n_oe_o, output_enable_o}, 5'h0f);
		i_host.read_status();
		step(2);
		check(overload_flag_o, 2'h1);
		overload_i = 2'h0;
		step(2);
		i_host.read_status();
		step(3);
		check({overload_flag_o, fault_pin_n_oe_o, output_enable_o}, 5'h03);
		i_host.write_ctrl(4'h5, 4'ha, 2'h1, 2'h0, 2'h0, 4'h2);
		overload_i = 2'h2;
		step(2000);
		check({overload_flag_o, output_enable_o}, 4'h3);
		overload_i = 2'h0;
		overtemp_i = 1'b1;
		step(8);
		check({overtemp_flag_o, boost_enable_o, output_enable_o}, 4'h8);
		overtemp_i = 1'b0;
		step(6);
		i_host.read_status();
		step(3);
		check({overtemp_flag_o, level_a_o, level_b_o, output_enable_o}, 11'h000);
		i_host.write_ctrl(4'h5, 4'ha, 2'h1, 2'h3, 2'h0, 4'h0);
		overtemp_i = 1'b1;
		step(8);
		check(output_enable_o, 2'h0);
		overtemp_i = 1'b0;
		step(8);
		check({overtemp_flag_o, level_a_o, level_b_o, output_enable_o}, 11'h56b);
		i_host.read_status();
		step(3);
		check(overtemp_flag_o, 1'b0);
		supply_diag_threshold_i = 1'b1;
		step(8);
		check({supply_low_flag_o, fault_pin_n_oe_o, fault_pin_n_o}, 3'h6);
		supply_diag_threshold_i = 1'b0;
		step(6);
		i_host.read_status();
		step(3);
		check({supply_low_flag_o, fault_pin_n_oe_o}, 2'h0);
		undervoltage_lockout_i = 1'b1;
		step(8);
		check({level_a_o, level_b_o, output_enable_o, i2c_enable_o}, 11'h000);
		summarize();
	end
endmodule : ldp_ctrl_bench
`default_nettype wire
